// File: logic/gp_cfg.svh
`ifndef GP_CFG_SVH
`define GP_CFG_SVH

// ==========================================================
// Port geometry and bus
`define GP_NPIN 8
`define GP_ADDR_W 8
`define GP_RESP_OKAY 2'b00
`define GP_RESP_SLVERR 2'b10

// ==========================================================
// Register byte offsets
`define GP_OFS_DATA 8'h00
`define GP_OFS_DIR 8'h04
`define GP_OFS_DRV_LO 8'h08
`define GP_OFS_DRV_HI 8'h0c
`define GP_OFS_FN_LO 8'h10
`define GP_OFS_FN_HI 8'h14

// ==========================================================
// Reset values
`define GP_RST_DATA 8'h00
`define GP_RST_DIR 8'h00
`define GP_RST_DRV 8'h00
`define GP_RST_FN 8'h00

// ==========================================================
// Field codes
`define GP_DIR_OUT 1'b0
`define GP_DRV_HIZ 2'b00
`define GP_DRV_PCH 2'b01
`define GP_DRV_NCH 2'b10
`define GP_DRV_CMOS 2'b11
`define GP_FN_GPIO 2'b00
`define GP_FN_ALT1 2'b01
`define GP_FN_ALT2 2'b10
`define GP_FN_ALT3 2'b11
`define GP_IDLE_IN 1'b1

`endif

// File: logic/gp_pkg.sv
package gp_pkg;

  // How a pin is owned after function decode
  typedef enum logic [1:0] {
    role_gpio,
    role_periph,
    role_reserved
  } gp_role_e;

endpackage : gp_pkg

// File: logic/gp_sync.sv
`timescale 1ns/100ps
`include "gp_cfg.svh"

// Two-stage synchroniser for the asynchronous pad levels
module gp_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pad levels in, sampled levels out
  input wire logic [`GP_NPIN-1:0] async_in,
  output logic [`GP_NPIN-1:0] sync_out
);

  logic [`GP_NPIN-1:0] meta_ff;
  logic [`GP_NPIN-1:0] sync_ff;

  // First stage is read by the second stage only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : gp_sync

// File: logic/gp_drive.sv
`timescale 1ns/100ps
`include "gp_cfg.svh"

// Per-pin drive stage: direction, drive code and owner to pad controls
module gp_drive
  import gp_pkg::*;
(
  // Pin configuration
  input wire logic dir,
  input wire logic [1:0] drv,
  input gp_role_e role,
  // Candidate values
  input wire logic data_val,
  input wire logic alt_val,
  input wire logic alt_oe,
  // Pad controls
  output logic pad_out,
  output logic pad_oe,
  output logic pull_up,
  output logic pull_down
);

  logic val;
  logic en;

  // Reserved code forces a low level; open drain P then floats
  always_comb begin
    val = 1'b0;
    en = 1'b1;
    case (role)
      role_gpio: val = data_val;
      role_periph: begin
        val = alt_val;
        en = alt_oe;
      end
      default: val = 1'b0;
    endcase
  end

  // Output modes drive, input modes only pull
  always_comb begin
    pad_out = 1'b0;
    pad_oe = 1'b0;
    pull_up = 1'b0;
    pull_down = 1'b0;
    if (dir == `GP_DIR_OUT) begin
      case (drv)
        `GP_DRV_PCH: begin
          pad_out = 1'b1;
          pad_oe = en & val;
        end
        `GP_DRV_NCH: begin
          pad_out = 1'b0;
          pad_oe = en & ~val;
        end
        `GP_DRV_CMOS: begin
          pad_out = val;
          pad_oe = en;
        end
        default: pad_oe = 1'b0;
      endcase
    end else begin
      pull_down = (drv == `GP_DRV_PCH);
      pull_up = (drv == `GP_DRV_NCH);
    end
  end

endmodule : gp_drive

// File: logic/gp_port.sv
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "gp_cfg.svh"

// Function
// - Pin 2 function: gpio, uart A receive, serial data out, reserved.
// - Pin 1 function: gpio, I2C clock, serial clock, reserved.
// - Pin 0 function: gpio, I2C data, serial data in, reserved.
// - All function fields reset to general-purpose I/O.
// - Reserved, output, high-impedance drive: pin floats regardless of data.
// - Reserved, output, P-channel open drain: pin floats.
// - Reserved, output, N-channel open drain: pin driven low.
// - Reserved, output, push-pull drive: pin driven low.
// - Each pin has its own direction bit.
// - Output drive codes: high-z, P open drain, N open drain, push-pull.
// - Input codes: plain, pull-down, pull-up input.
// - Reset leaves every pin in high-impedance output mode.
// - Gpio output drives the data register bit.
// - Data read in input mode returns sampled pin level.
// - Peripheral lines reach pins by each pin's function bits.
// - Direction 0 is output, 1 is input.
// - Drive code table shared by output and input modes.
// - Pins 7 to 4: code 10 picks peripheral, 01 and 11 reserved.
// - Pin 3: uart A transmit, pulse output A, uart B transmit.
module gp_port
  import gp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [`GP_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [`GP_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Pads
  input wire logic [`GP_NPIN-1:0] pad_in,
  output logic [`GP_NPIN-1:0] pad_out,
  output logic [`GP_NPIN-1:0] pad_oe,
  output logic [`GP_NPIN-1:0] pad_pull_up,
  output logic [`GP_NPIN-1:0] pad_pull_down,
  // Peripheral outputs toward pins
  input wire logic i2c_sda_out,
  input wire logic i2c_sda_oe,
  input wire logic i2c_scl_out,
  input wire logic i2c_scl_oe,
  input wire logic sync_serial_clock_out,
  input wire logic sync_serial_clock_oe,
  input wire logic sync_serial_data_out,
  input wire logic uart_a_transmit,
  input wire logic uart_b_transmit,
  input wire logic pulse_width_out_a,
  input wire logic pulse_width_out_b,
  // Pin levels toward peripherals
  output logic i2c_sda_in,
  output logic i2c_scl_in,
  output logic sync_serial_clock_in,
  output logic sync_serial_data_in,
  output logic uart_a_receive
);

  // ==========================================================
  // Registers and internal signals
  logic [7:0] port_pin_data_reg_ff;
  logic [7:0] port_direction_reg_ff;
  logic [7:0] drive_select_low_reg_ff;
  logic [7:0] drive_select_high_reg_ff;
  logic [7:0] pin_function_select_low_ff;
  logic [7:0] pin_function_select_high_ff;

  logic aw_held_ff;
  logic w_held_ff;
  logic [`GP_ADDR_W-1:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wlane_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  logic [`GP_NPIN-1:0] pin_level;
  gp_role_e role [`GP_NPIN];
  logic [`GP_NPIN-1:0] alt_val;
  logic [`GP_NPIN-1:0] alt_oe;
  logic [`GP_NPIN-1:0] nxt_pad_out;
  logic [`GP_NPIN-1:0] nxt_pad_oe;
  logic [`GP_NPIN-1:0] nxt_pull_up;
  logic [`GP_NPIN-1:0] nxt_pull_down;
  logic [`GP_NPIN-1:0] pad_out_ff;
  logic [`GP_NPIN-1:0] pad_oe_ff;
  logic [`GP_NPIN-1:0] pull_up_ff;
  logic [`GP_NPIN-1:0] pull_down_ff;
  logic [4:0] periph_in_ff;
  logic do_write;
  logic wr_hit;

  // ==========================================================
  // Helper functions

  // True when the address names one of the six registers
  function automatic logic addr_hit(input logic [`GP_ADDR_W-1:0] a);
    addr_hit = (a == `GP_OFS_DATA) || (a == `GP_OFS_DIR) ||
               (a == `GP_OFS_DRV_LO) || (a == `GP_OFS_DRV_HI) ||
               (a == `GP_OFS_FN_LO) || (a == `GP_OFS_FN_HI);
  endfunction : addr_hit

  // Two-bit function code of one pin
  function automatic logic [1:0] fn_code(input int idx,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo);
    fn_code = {hi[idx], lo[idx]};
  endfunction : fn_code

  // ==========================================================
  // Pad synchroniser
  gp_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pad_in),
    .sync_out(pin_level)
  );

  // ==========================================================
  // AXI4-Lite write path

  // Address and data are taken in either order, one write in flight
  assign awready = !aw_held_ff && !bvalid_ff;
  assign wready = !w_held_ff && !bvalid_ff;
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_hit = addr_hit(awaddr_ff);

  // Capture the write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (awvalid && awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  // Capture the write data; only the low lane carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wbyte_ff <= '0;
      wlane_ff <= 1'b0;
    end else if (wvalid && wready) begin
      w_held_ff <= 1'b1;
      wbyte_ff <= wdata[7:0];
      wlane_ff <= wstrb[0];
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  // Response follows both halves; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `GP_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // ==========================================================
  // Configuration registers

  // Data register keeps what was written, even in input mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_pin_data_reg_ff <= `GP_RST_DATA;
    end else if (do_write && wlane_ff && awaddr_ff == `GP_OFS_DATA) begin
      port_pin_data_reg_ff <= wbyte_ff;
    end
  end

  // Direction resets to output so pins start as high-z outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_direction_reg_ff <= `GP_RST_DIR;
    end else if (do_write && wlane_ff && awaddr_ff == `GP_OFS_DIR) begin
      port_direction_reg_ff <= wbyte_ff;
    end
  end

  // Drive code pair, low and high halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_select_low_reg_ff <= `GP_RST_DRV;
      drive_select_high_reg_ff <= `GP_RST_DRV;
    end else if (do_write && wlane_ff) begin
      if (awaddr_ff == `GP_OFS_DRV_LO) begin
        drive_select_low_reg_ff <= wbyte_ff;
      end else if (awaddr_ff == `GP_OFS_DRV_HI) begin
        drive_select_high_reg_ff <= wbyte_ff;
      end
    end
  end

  // Function select pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_function_select_low_ff <= `GP_RST_FN;
      pin_function_select_high_ff <= `GP_RST_FN;
    end else if (do_write && wlane_ff) begin
      if (awaddr_ff == `GP_OFS_FN_LO) begin
        pin_function_select_low_ff <= wbyte_ff;
      end else if (awaddr_ff == `GP_OFS_FN_HI) begin
        pin_function_select_high_ff <= wbyte_ff;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path

  // One read in flight; the answer comes one cycle after the address
  assign arready = !rvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= `GP_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= `GP_RESP_OKAY;
      if (araddr == `GP_OFS_DATA) begin
        // Input pins show the sampled level, outputs the stored bit
        rdata_ff <= {24'h000000,
                     (port_direction_reg_ff & pin_level) |
                     (~port_direction_reg_ff & port_pin_data_reg_ff)};
      end else if (araddr == `GP_OFS_DIR) begin
        rdata_ff <= {24'h000000, port_direction_reg_ff};
      end else if (araddr == `GP_OFS_DRV_LO) begin
        rdata_ff <= {24'h000000, drive_select_low_reg_ff};
      end else if (araddr == `GP_OFS_DRV_HI) begin
        rdata_ff <= {24'h000000, drive_select_high_reg_ff};
      end else if (araddr == `GP_OFS_FN_LO) begin
        rdata_ff <= {24'h000000, pin_function_select_low_ff};
      end else if (araddr == `GP_OFS_FN_HI) begin
        rdata_ff <= {24'h000000, pin_function_select_high_ff};
      end else begin
        rdata_ff <= '0;
        rresp_ff <= `GP_RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // ==========================================================
  // Function decode per pin

  // Unlisted codes fall to reserved; input-only functions never drive
  always_comb begin
    logic [1:0] code;
    code = `GP_FN_GPIO;
    for (int i = 0; i < `GP_NPIN; i++) begin
      code = fn_code(i, pin_function_select_high_ff,
                     pin_function_select_low_ff);
      role[i] = role_reserved;
      alt_val[i] = 1'b0;
      alt_oe[i] = 1'b0;
      if (code == `GP_FN_GPIO) begin
        role[i] = role_gpio;
      end else begin
        case (i)
          0: begin
            if (code == `GP_FN_ALT1) begin
              role[i] = role_periph;
              alt_val[i] = i2c_sda_out;
              alt_oe[i] = i2c_sda_oe;
            end else if (code == `GP_FN_ALT2) begin
              role[i] = role_periph;
            end
          end
          1: begin
            if (code == `GP_FN_ALT1) begin
              role[i] = role_periph;
              alt_val[i] = i2c_scl_out;
              alt_oe[i] = i2c_scl_oe;
            end else if (code == `GP_FN_ALT2) begin
              role[i] = role_periph;
              alt_val[i] = sync_serial_clock_out;
              alt_oe[i] = sync_serial_clock_oe;
            end
          end
          2: begin
            if (code == `GP_FN_ALT1) begin
              role[i] = role_periph;
            end else if (code == `GP_FN_ALT2) begin
              role[i] = role_periph;
              alt_val[i] = sync_serial_data_out;
              alt_oe[i] = 1'b1;
            end
          end
          3: begin
            role[i] = role_periph;
            alt_oe[i] = 1'b1;
            if (code == `GP_FN_ALT1) begin
              alt_val[i] = uart_a_transmit;
            end else if (code == `GP_FN_ALT2) begin
              alt_val[i] = pulse_width_out_a;
            end else begin
              alt_val[i] = uart_b_transmit;
            end
          end
          4: begin
            if (code == `GP_FN_ALT2) begin
              role[i] = role_periph;
            end
          end
          5: begin
            if (code == `GP_FN_ALT2) begin
              role[i] = role_periph;
              alt_val[i] = sync_serial_clock_out;
              alt_oe[i] = sync_serial_clock_oe;
            end
          end
          6: begin
            if (code == `GP_FN_ALT2) begin
              role[i] = role_periph;
              alt_val[i] = sync_serial_data_out;
              alt_oe[i] = 1'b1;
            end
          end
          default: begin
            if (code == `GP_FN_ALT2) begin
              role[i] = role_periph;
              alt_val[i] = pulse_width_out_b;
              alt_oe[i] = 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Drive stage, one per pin
  for (genvar g = 0; g < `GP_NPIN; g++) begin : g_pin
    gp_drive u_drive (
      .dir(port_direction_reg_ff[g]),
      .drv({drive_select_high_reg_ff[g], drive_select_low_reg_ff[g]}),
      .role(role[g]),
      .data_val(port_pin_data_reg_ff[g]),
      .alt_val(alt_val[g]),
      .alt_oe(alt_oe[g]),
      .pad_out(nxt_pad_out[g]),
      .pad_oe(nxt_pad_oe[g]),
      .pull_up(nxt_pull_up[g]),
      .pull_down(nxt_pull_down[g])
    );
  end

  // Registered pad controls keep glitches off the pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out_ff <= '0;
      pad_oe_ff <= '0;
      pull_up_ff <= '0;
      pull_down_ff <= '0;
    end else begin
      pad_out_ff <= nxt_pad_out;
      pad_oe_ff <= nxt_pad_oe;
      pull_up_ff <= nxt_pull_up;
      pull_down_ff <= nxt_pull_down;
    end
  end

  assign pad_out = pad_out_ff;
  assign pad_oe = pad_oe_ff;
  assign pad_pull_up = pull_up_ff;
  assign pad_pull_down = pull_down_ff;

  // ==========================================================
  // Pin levels to peripherals

  // Unrouted inputs idle high so receivers see a quiet line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_in_ff <= {5{`GP_IDLE_IN}};
    end else begin
      periph_in_ff[0] <= (role[0] == role_periph &&
                          !pin_function_select_high_ff[0]) ?
                         pin_level[0] : `GP_IDLE_IN;
      periph_in_ff[1] <= (role[1] == role_periph &&
                          !pin_function_select_high_ff[1]) ?
                         pin_level[1] : `GP_IDLE_IN;
      periph_in_ff[2] <= (role[2] == role_periph &&
                          !pin_function_select_high_ff[2]) ?
                         pin_level[2] : `GP_IDLE_IN;
      // Pin 0 wins when both serial data inputs are selected
      if (role[0] == role_periph && pin_function_select_high_ff[0]) begin
        periph_in_ff[3] <= pin_level[0];
      end else if (role[4] == role_periph) begin
        periph_in_ff[3] <= pin_level[4];
      end else begin
        periph_in_ff[3] <= `GP_IDLE_IN;
      end
      // Pin 1 wins when both serial clock pins are selected
      if (role[1] == role_periph && pin_function_select_high_ff[1]) begin
        periph_in_ff[4] <= pin_level[1];
      end else if (role[5] == role_periph) begin
        periph_in_ff[4] <= pin_level[5];
      end else begin
        periph_in_ff[4] <= `GP_IDLE_IN;
      end
    end
  end

  assign i2c_sda_in = periph_in_ff[0];
  assign i2c_scl_in = periph_in_ff[1];
  assign uart_a_receive = periph_in_ff[2];
  assign sync_serial_data_in = periph_in_ff[3];
  assign sync_serial_clock_in = periph_in_ff[4];

endmodule : gp_port

// File: verification/gp_port_monitor.sv
`timescale 1ns/100ps

// Watches the bus handshakes and pad controls of the port
module gp_port_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Pad controls
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pull_up,
  input wire logic [7:0] pad_pull_down
);
  // ==========================================================
  // Checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Reset leaves every pin undriven with no pull-up, and no answer pending
  rst_quiet_a: assert property ($past(!aresetn) |->
    pad_oe == 8'h00 && pad_pull_up == 8'h00 && !bvalid && !rvalid)
    else $error("pins or bus busy after reset");
  rd_lat_a: assert property (arvalid && arready |=> rvalid && !rresp[0])
    else $error("read answer late");
  rd_hold_a: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  ar_block_a: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  wr_resp_a: assert property (awvalid && awready && wvalid && wready
    |-> ##[1:3] bvalid) else $error("write answer late");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  aw_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  // Pulls only on undriven pins, never both at once
  pull_excl_a: assert property ((pad_pull_up & pad_pull_down) == 8'h00)
    else $error("both pulls on");
  pull_noe_a: assert property (
    ((pad_pull_up | pad_pull_down) & pad_oe) == 8'h00)
    else $error("pull on a driven pin");
  rd_high_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule : gp_port_monitor

bind gp_port gp_port_monitor mon_u (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .rresp(rresp), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
  .pad_pull_down(pad_pull_down));

// File: verification/gp_pin_model.sv
`timescale 1ns/100ps

// Board side of the eight pins: resolves each pin level
module gp_pin_model (
  // Clock
  input wire logic aclk,
  // Pad controls from the port
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] pull_down,
  // Board drivers
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_oe,
  // Resolved levels
  output logic [7:0] pad_in
);
  logic [7:0] flt_ff = 8'h55;

  // A floating pin wanders so that no fixed level can be trusted
  always_ff @(posedge aclk) begin
    flt_ff <= ~flt_ff;
  end

  // Port drive first, then board drive, then pulls
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_oe[i]) pad_in[i] = ext_val[i];
      else if (pull_up[i]) pad_in[i] = 1'b1;
      else if (pull_down[i]) pad_in[i] = 1'b0;
      else pad_in[i] = flt_ff[i];
    end
  end
endmodule : gp_pin_model

// File: verification/gpio_port_function_select_bench.sv
`timescale 1ns/100ps
`include "gp_cfg.svh"

module gpio_port_function_select_bench;
  // ==========================================================
  // Signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] awaddr, araddr, ext_val, ext_oe, pad_in, pad_out, pad_oe;
  logic [7:0] pad_pull_up, pad_pull_down;
  logic [31:0] wdata, rdata;
  logic [10:0] per_o;
  logic [4:0] per_i;
  int n_errors, cmp_count;

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  gp_port dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'h1), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .i2c_sda_out(per_o[0]),
    .i2c_sda_oe(per_o[1]), .i2c_scl_out(per_o[2]), .i2c_scl_oe(per_o[3]),
    .sync_serial_clock_out(per_o[4]), .sync_serial_clock_oe(per_o[5]),
    .sync_serial_data_out(per_o[6]), .uart_a_transmit(per_o[7]),
    .uart_b_transmit(per_o[8]), .pulse_width_out_a(per_o[9]),
    .pulse_width_out_b(per_o[10]), .i2c_sda_in(per_i[4]),
    .sync_serial_clock_in(per_i[3]), .uart_a_receive(per_i[2]),
    .i2c_scl_in(per_i[1]), .sync_serial_data_in(per_i[0]));

  gp_pin_model pin_u (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up(pad_pull_up), .pull_down(pad_pull_down), .ext_val(ext_val),
    .ext_oe(ext_oe), .pad_in(pad_in));

  // ==========================================================
  // Reporting
  task close_out;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, s, e);
    end
  endtask : chk

  // Expected pad controls {out&oe, oe, pull_up, pull_down}
  function automatic logic [31:0] ex(input logic [7:0] dir, lo, hi, v);
    logic [7:0] o, oe, pu, pd;
    for (int i = 0; i < 8; i++) begin
      pu[i] = dir[i] && {hi[i], lo[i]} == 2'b10;
      pd[i] = dir[i] && {hi[i], lo[i]} == 2'b01;
      o[i] = !dir[i] && (hi[i] ? lo[i] & v[i] : lo[i]);
      oe[i] = !dir[i] && (hi[i] ? lo[i] | !v[i] : lo[i] & v[i]);
    end
    return {o & oe, oe, pu, pd};
  endfunction : ex

  task pchk(input logic [31:0] e);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({pad_out & pad_oe, pad_oe, pad_pull_up, pad_pull_down}, e);
  endtask : pchk

  // ==========================================================
  // Bus tasks; the answer is held off for st cycles to test stalls
  task automatic wr(input logic [7:0] a, d, input int st = 0);
    logic aw_h, w_h, b_h;
    logic [1:0] rs;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (st == 0);
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      {aw_h, w_h} = {awvalid && awready, wvalid && wready};
      b_h = bvalid && bready;
      rs = bresp;
      @(posedge aclk);
      if (aw_h) awvalid <= 1'b0;
      if (w_h) wvalid <= 1'b0;
      if (b_h) begin
        bready <= 1'b0;
        break;
      end else if (i + 1 >= st) bready <= 1'b1;
    end
    if (!b_h) n_errors++;
    if (!b_h) close_out;
    chk({30'h0, rs}, (a > 8'h14) ? `GP_RESP_SLVERR : `GP_RESP_OKAY);
  endtask : wr

  task automatic rd(input logic [7:0] a, e, input int st = 0);
    logic ar_h, r_h;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (st == 0);
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      {ar_h, r_h} = {arvalid && arready, rvalid && rready};
      {d, rs} = {rdata, rresp};
      @(posedge aclk);
      if (ar_h) arvalid <= 1'b0;
      if (r_h) begin
        rready <= 1'b0;
        break;
      end else if (i + 1 >= st) rready <= 1'b1;
    end
    if (!r_h) n_errors++;
    if (!r_h) close_out;
    chk(d, {24'h0, e});
    chk({30'h0, rs}, (a > 8'h14) ? `GP_RESP_SLVERR : `GP_RESP_OKAY);
  endtask : rd

  // ==========================================================
  // Scenarios
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, ext_val, ext_oe, per_o} = 'h0;
    {n_errors, cmp_count} = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 8'h00);
    pchk(32'h0);
    // Unmapped word, answers held back by the master
    rd(8'h18, 8'h00, 3);
    wr(8'h18, 8'h5a, 3);
    // Every drive code, low nibble as inputs
    wr(`GP_OFS_DATA, 8'ha5);
    wr(`GP_OFS_DIR, 8'h0f);
    for (int k = 0; k < 4; k++) begin
      wr(`GP_OFS_DRV_LO, {8{k[0]}});
      wr(`GP_OFS_DRV_HI, {8{k[1]}});
      pchk(ex(8'h0f, {8{k[0]}}, {8{k[1]}}, 8'ha5));
    end
    // Inputs read the pin, outputs read back the written value
    ext_oe <= 8'h0f;
    ext_val <= 8'h3c;
    repeat (5) @(posedge aclk);
    rd(`GP_OFS_DATA, 8'hac);
    // Reserved codes on pins 2:0 and 7:4, pin 3 left plain
    ext_oe <= 8'h00;
    wr(`GP_OFS_DIR, 8'h00);
    wr(`GP_OFS_DATA, 8'hff);
    wr(`GP_OFS_FN_LO, 8'hf7);
    wr(`GP_OFS_FN_HI, 8'h07);
    for (int k = 0; k < 4; k++) begin
      wr(`GP_OFS_DRV_LO, {8{k[0]}});
      wr(`GP_OFS_DRV_HI, {8{k[1]}});
      pchk(ex(8'h00, {8{k[0]}}, {8{k[1]}}, 8'h08));
    end
    // Pin 3 sources: only the selected one is high
    wr(`GP_OFS_DATA, 8'h00);
    for (int k = 1; k < 4; k++) begin
      @(posedge aclk) per_o <= {1'b0, k == 2, k == 3, k == 1, 7'h0};
      wr(`GP_OFS_FN_LO, {4'h0, k[0], 3'h0});
      wr(`GP_OFS_FN_HI, {4'h0, k[1], 3'h0});
      pchk(ex(8'h00, 8'hff, 8'hff, 8'h08));
    end
    // Pins 7:4 on their peripherals; serial input pin 4 stays undriven
    @(posedge aclk) per_o <= 11'h470;
    wr(`GP_OFS_FN_LO, 8'h00);
    wr(`GP_OFS_FN_HI, 8'hf0);
    pchk(32'he0ef0000);
    // Pins 2:0 feed the peripherals; unrouted inputs idle high
    wr(`GP_OFS_FN_LO, 8'h05);
    wr(`GP_OFS_FN_HI, 8'h02);
    wr(`GP_OFS_DIR, 8'hff);
    ext_oe <= 8'hff;
    for (int k = 0; k < 8; k += 7) begin
      ext_val <= 8'(k);
      repeat (6) @(posedge aclk);
      @(negedge aclk);
      chk({27'h0, per_i}, {27'h0, k[0], k[1], k[2], 2'b11});
    end
    // Second reset in mid run
    @(posedge aclk) aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`GP_OFS_FN_LO, 8'h00);
    pchk(32'h0);
    close_out;
  end
endmodule : gpio_port_function_select_bench
